// ==== logic/rxsc_defs.vh ====
// Register map, thresholds and reset values of the receive statistics block
`ifndef RXSC_DEFS_VH
`define RXSC_DEFS_VH

// Counter register byte addresses
`define RXSC_GIANT_CRC_ADDR   32'h440001A0
`define RXSC_SHORT_GOOD_ADDR  32'h440001A4
`define RXSC_LONG_GOOD_ADDR   32'h440001A8
`define RXSC_BIN_64_ADDR      32'h440001AC
`define RXSC_BIN_65_ADDR      32'h440001B0
`define RXSC_BIN_128_ADDR     32'h440001B4
`define RXSC_BIN_256_ADDR     32'h440001B8
`define RXSC_BIN_512_ADDR     32'h440001BC
`define RXSC_BIN_1024_ADDR    32'h440001C0
`define RXSC_UNICAST_ADDR     32'h440001C4
`define RXSC_LEN_MISM_ADDR    32'h440001C8
`define RXSC_TYPE_OOR_ADDR    32'h440001CC
`define RXSC_PAUSE_ADDR       32'h440001D0
`define RXSC_OVF_DROP_ADDR    32'h440001D4

// Configuration register (size options)
`define RXSC_CFG_ADDR         32'h440001F0
`define RXSC_CFG_RESET        32'h00000000
`define RXSC_CFG_JUMBO_BIT    20
`define RXSC_CFG_SIZE2K_BIT   27

// Counter indices and count
`define RXSC_IDX_GIANT        0
`define RXSC_IDX_SHORT        1
`define RXSC_IDX_LONG         2
`define RXSC_IDX_BIN64        3
`define RXSC_IDX_BIN65        4
`define RXSC_IDX_BIN128       5
`define RXSC_IDX_BIN256       6
`define RXSC_IDX_BIN512       7
`define RXSC_IDX_BIN1024      8
`define RXSC_IDX_UNICAST      9
`define RXSC_IDX_LEN_MISM     10
`define RXSC_IDX_TYPE_OOR     11
`define RXSC_IDX_PAUSE        12
`define RXSC_IDX_OVF_DROP     13
`define RXSC_NUM_CNT          14

// Counter widths: wide (32-bit) counters are marked in this mask
`define RXSC_WIDE_MASK        14'h03F8
`define RXSC_WIDE_W           32
`define RXSC_NARROW_W         16
`define RXSC_CNT_RESET        32'h00000000

// Frame length thresholds in bytes (CRC included, preamble excluded)
`define RXSC_STD_MAX          14'h05EE
`define RXSC_VLAN_MAX         14'h05F2
`define RXSC_JUMBO_MAX        14'h233A
`define RXSC_JUMBO_VLAN_MAX   14'h233E
`define RXSC_SIZE2K_MAX       14'h07D0
`define RXSC_MIN_FRAME        14'h0040
`define RXSC_BIN_65           14'h0041
`define RXSC_BIN_127          14'h007F
`define RXSC_BIN_128          14'h0080
`define RXSC_BIN_255          14'h00FF
`define RXSC_BIN_256          14'h0100
`define RXSC_BIN_511          14'h01FF
`define RXSC_BIN_512          14'h0200
`define RXSC_BIN_1023         14'h03FF
`define RXSC_BIN_1024         14'h0400

// Length/type field limits and header overheads
`define RXSC_LT_MAX_LEN       16'h05DC
`define RXSC_LT_MIN_TYPE      16'h0600
`define RXSC_HDR_STD          14'h0012
`define RXSC_HDR_VLAN         14'h0016
`define RXSC_MIN_PAYLOAD      14'h002E
`define RXSC_MIN_PAYLOAD_VLAN 14'h002A

`endif

// ==== logic/rxsc_counter.v ====
// One read-only statistics counter that wraps at its own width
`timescale 1ns/1ps
`include "rxsc_defs.vh"

module rxsc_counter #(
  parameter CNT_W = 32
) (
  input  wire        ref_clk,
  input  wire        sys_rst,
  input  wire        inc,
  output wire [31:0] count
);

  // Bits above CNT_W are held at zero so they read as zero
  localparam [31:0] CNT_MASK = {32{1'b1}} >> (32 - CNT_W);

  reg  [31:0] count_r;   // Current count
  wire [31:0] count_nxt; // Count after one more frame

  // All-ones plus one lands on zero through the mask
  assign count_nxt = (count_r + 32'h00000001) & CNT_MASK;

  // Advance by one per qualifying frame, clear on reset
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      count_r <= `RXSC_CNT_RESET;
    end else if (inc) begin
      count_r <= count_nxt;
    end
  end

  assign count = count_r;

endmodule // rxsc_counter

// ==== logic/rxsc_top.v ====
// Receive frame statistics counters with register read port
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`include "rxsc_defs.vh"

module rxsc_top #(
  parameter LEN_W = 14
) (
  input  wire             ref_clk,
  input  wire             sys_rst,
  input  wire             frm_done,
  input  wire [LEN_W-1:0] frm_len,
  input  wire [15:0]      frm_len_type,
  input  wire             frm_vlan,
  input  wire             frm_crc_err,
  input  wire             frm_any_err,
  input  wire             frm_unicast,
  input  wire             frm_pause_ok,
  input  wire             frm_retried,
  input  wire             frm_ovf_drop,
  input  wire [31:0]      reg_addr,
  input  wire [31:0]      reg_wdata,
  input  wire             reg_wr,
  input  wire             reg_rd,
  output wire [31:0]      reg_rdata,
  output wire             cfg_jumbo_en,
  output wire             cfg_size2k_en
);

  // ---------------------------------------------------------------
  // Configuration register
  // ---------------------------------------------------------------

  reg  [31:0] cfg_r;   // Size option bits
  wire [31:0] cfg_nxt; // Next value of the size options

  // Only the two option bits are kept, the rest read as zero
  assign cfg_nxt = reg_wdata & ((32'h00000001 << `RXSC_CFG_JUMBO_BIT)
                               | (32'h00000001 << `RXSC_CFG_SIZE2K_BIT));

  // Software updates the size options with a write strobe
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      cfg_r <= `RXSC_CFG_RESET;
    end else if (reg_wr && (reg_addr == `RXSC_CFG_ADDR)) begin
      cfg_r <= cfg_nxt;
    end
  end

  // Option bits fed back out for the rest of the MAC
  assign cfg_jumbo_en  = cfg_r[`RXSC_CFG_JUMBO_BIT];
  assign cfg_size2k_en = cfg_r[`RXSC_CFG_SIZE2K_BIT];

  // ---------------------------------------------------------------
  // Frame capture stage
  // ---------------------------------------------------------------

  reg             evt_r;       // Frame report taken last cycle
  reg [LEN_W-1:0] len_r;       // Frame length with CRC
  reg [15:0]      lt_r;        // Length/type field
  reg             vlan_r;      // Frame carried a VLAN tag
  reg             crc_err_r;   // CRC error seen
  reg             any_err_r;   // Any error seen
  reg             unicast_r;   // Destination was unicast
  reg             pause_ok_r;  // PAUSE frame found valid
  reg             retried_r;   // Frame was a retry
  reg             ovf_r;       // Frame dropped by FIFO overflow

  // Register the frame report so the compares start from flops
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      evt_r      <= 1'b0;
      len_r      <= {LEN_W{1'b0}};
      lt_r       <= 16'h0000;
      vlan_r     <= 1'b0;
      crc_err_r  <= 1'b0;
      any_err_r  <= 1'b0;
      unicast_r  <= 1'b0;
      pause_ok_r <= 1'b0;
      retried_r  <= 1'b0;
      ovf_r      <= 1'b0;
    end else begin
      evt_r <= frm_done;
      ovf_r <= frm_ovf_drop;
      // Details are only loaded with a report
      if (frm_done) begin
        len_r      <= frm_len;
        lt_r       <= frm_len_type;
        vlan_r     <= frm_vlan;
        crc_err_r  <= frm_crc_err;
        any_err_r  <= frm_any_err;
        unicast_r  <= frm_unicast;
        pause_ok_r <= frm_pause_ok;
        retried_r  <= frm_retried;
      end
    end
  end

  // ---------------------------------------------------------------
  // Size limits chosen by tag and options
  // ---------------------------------------------------------------

  reg [LEN_W-1:0] giant_lim; // Length above which a frame is giant
  reg [LEN_W-1:0] max_size;  // Largest frame that is not oversize

  // Giant limit follows jumbo mode and the tag
  always @* begin
    if (cfg_jumbo_en) begin
      // Jumbo frames move the giant limit up
      giant_lim = vlan_r ? `RXSC_JUMBO_VLAN_MAX : `RXSC_JUMBO_MAX;
    end else begin
      // Standard limits
      giant_lim = vlan_r ? `RXSC_VLAN_MAX : `RXSC_STD_MAX;
    end
  end

  // Maxsize follows the 2000-byte option and the tag
  always @* begin
    if (cfg_size2k_en) begin
      // 2000-byte option overrides the tag
      max_size = `RXSC_SIZE2K_MAX;
    end else begin
      // Standard maxsize
      max_size = vlan_r ? `RXSC_VLAN_MAX : `RXSC_STD_MAX;
    end
  end

  // ---------------------------------------------------------------
  // Length field check
  // ---------------------------------------------------------------

  wire [LEN_W-1:0] hdr_len;    // Header plus CRC bytes
  wire [LEN_W-1:0] pay_len;    // Payload bytes actually received
  wire [LEN_W-1:0] pad_len;    // Payload size of a padded frame
  wire [15:0]      pay_len_w;  // Payload at the field's width
  wire             lt_is_len;  // Field holds a length
  wire             lt_oor;     // Field is in the forbidden gap
  reg              len_mism;   // Field disagrees with frame size

  assign hdr_len   = vlan_r ? `RXSC_HDR_VLAN : `RXSC_HDR_STD;
  assign pay_len   = (len_r > hdr_len) ? (len_r - hdr_len) : {LEN_W{1'b0}};
  assign pad_len   = vlan_r ? `RXSC_MIN_PAYLOAD_VLAN : `RXSC_MIN_PAYLOAD;
  assign pay_len_w = {{(16 - LEN_W){1'b0}}, pay_len};
  assign lt_is_len = (lt_r <= `RXSC_LT_MAX_LEN);

  // Gap between largest length and smallest type value
  assign lt_oor = (lt_r > `RXSC_LT_MAX_LEN) && (lt_r < `RXSC_LT_MIN_TYPE);

  // Compare only when the field is a length
  always @* begin
    len_mism = 1'b0;
    if (lt_is_len) begin
      if (lt_r > pay_len_w) begin
        // Field claims more data than arrived
        len_mism = 1'b1;
      end else if (lt_r < pay_len_w) begin
        // Shorter field is fine only when the payload is just padding
        len_mism = (pay_len != pad_len);
      end else begin
        // Exact match
        len_mism = 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Frame classification
  // ---------------------------------------------------------------

  wire                    good;     // Frame had no error
  reg [`RXSC_NUM_CNT-1:0] cnt_inc;  // One increment per counter

  assign good = ~any_err_r;

  // Each counter's condition, qualified by the frame report except the overflow drop count
  always @* begin
    cnt_inc = {`RXSC_NUM_CNT{1'b0}};
    if (evt_r) begin
      // Giant and CRC error together
      cnt_inc[`RXSC_IDX_GIANT] = (len_r > giant_lim) && crc_err_r;
      // Short error-free frames
      cnt_inc[`RXSC_IDX_SHORT] = good && (len_r < `RXSC_MIN_FRAME);
      // Long error-free frames
      cnt_inc[`RXSC_IDX_LONG]  = good && (len_r > max_size);
      // Histogram bins take good and bad frames alike
      cnt_inc[`RXSC_IDX_BIN64] = (len_r == `RXSC_MIN_FRAME);
      cnt_inc[`RXSC_IDX_BIN65] = (len_r >= `RXSC_BIN_65)
                               && (len_r <= `RXSC_BIN_127);
      cnt_inc[`RXSC_IDX_BIN128] = (len_r >= `RXSC_BIN_128)
                                && (len_r <= `RXSC_BIN_255);
      cnt_inc[`RXSC_IDX_BIN256] = (len_r >= `RXSC_BIN_256)
                                && (len_r <= `RXSC_BIN_511);
      cnt_inc[`RXSC_IDX_BIN512] = (len_r >= `RXSC_BIN_512)
                                && (len_r <= `RXSC_BIN_1023);
      // Top bin stops at maxsize and skips retries
      cnt_inc[`RXSC_IDX_BIN1024] = (len_r >= `RXSC_BIN_1024)
                                 && (len_r <= max_size)
                                 && !retried_r;
      // Good unicast frames
      cnt_inc[`RXSC_IDX_UNICAST]  = good && unicast_r;
      // Length field disagreement
      cnt_inc[`RXSC_IDX_LEN_MISM] = len_mism;
      // Forbidden length/type values
      cnt_inc[`RXSC_IDX_TYPE_OOR] = lt_oor;
      // PAUSE must be good and valid
      cnt_inc[`RXSC_IDX_PAUSE]    = good && pause_ok_r;
    end
    // Dropped frames come on their own strobe
    cnt_inc[`RXSC_IDX_OVF_DROP] = ovf_r;
  end

  // ---------------------------------------------------------------
  // Counter bank
  // ---------------------------------------------------------------

  wire [32*`RXSC_NUM_CNT-1:0] cnt_flat; // All counts side by side

  // One counter per statistic, width taken from the wide mask
  genvar gi;
  generate
    for (gi = 0; gi < `RXSC_NUM_CNT; gi = gi + 1) begin : g_cnt
      localparam [`RXSC_NUM_CNT-1:0] WIDE_MASK = `RXSC_WIDE_MASK;
      localparam CW = WIDE_MASK[gi] ? `RXSC_WIDE_W : `RXSC_NARROW_W;
      rxsc_counter #(
        .CNT_W (CW)
      ) u_cnt (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .inc     (cnt_inc[gi]),
        .count   (cnt_flat[gi*32 +: 32])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // Register read port
  // ---------------------------------------------------------------

  reg  [31:0] rdata_r;   // Read data, valid the cycle after the strobe
  reg  [31:0] rdata_nxt; // Data selected by the address
  wire [31:0] addr_off;  // Address relative to the first counter
  wire [3:0]  rd_idx;    // Counter selected by the address
  wire        in_bank;   // Address falls on a counter

  assign addr_off = reg_addr - `RXSC_GIANT_CRC_ADDR;
  assign rd_idx   = addr_off[5:2];
  assign in_bank  = (addr_off[31:6] == 26'h0000000) && (addr_off[1:0] == 2'h0)
                  && (rd_idx < `RXSC_NUM_CNT);

  // Address decode; unmapped addresses read as zero
  always @* begin
    rdata_nxt = 32'h00000000;
    if (in_bank) begin
      // Counters are read only; writes to them do nothing
      rdata_nxt = cnt_flat[rd_idx*32 +: 32];
    end else if (reg_addr == `RXSC_CFG_ADDR) begin
      // Size options
      rdata_nxt = cfg_r;
    end else begin
      // Nothing mapped here
      rdata_nxt = 32'h00000000;
    end
  end

  // Hold read data for exactly the cycle after the strobe
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      rdata_r <= 32'h00000000;
    end else if (reg_rd) begin
      rdata_r <= rdata_nxt;
    end else begin
      rdata_r <= 32'h00000000;
    end
  end

  assign reg_rdata = rdata_r;

endmodule // rxsc_top

// ==== dv/rxsc_frm_src.sv ====
// Receive datapath model that hands classified frame events to the counters
`timescale 1ns/1ps

module rxsc_frm_src (
  input  wire         ref_clk,
  output logic        frm_done,
  output logic [13:0] frm_len,
  output logic [15:0] frm_len_type,
  output logic        frm_vlan,
  output logic        frm_crc_err,
  output logic        frm_any_err,
  output logic        frm_unicast,
  output logic        frm_pause_ok,
  output logic        frm_retried,
  output logic        frm_ovf_drop
);
  // Idle outputs at time zero
  initial begin
    frm_done = 1'b0;
    frm_ovf_drop = 1'b0;
    {frm_len, frm_len_type} = 30'h0;
    {frm_vlan, frm_crc_err, frm_any_err, frm_unicast, frm_pause_ok, frm_retried} = 6'h0;
  end

  // One frame; flags are vlan, crc, err, unicast, pause, retry
  task send(input [13:0] len, input [15:0] lt, input [5:0] fl);
    frm_done <= 1'b1;
    frm_len <= len;
    frm_len_type <= lt;
    {frm_vlan, frm_crc_err, frm_any_err, frm_unicast, frm_pause_ok, frm_retried} <= fl;
    @(posedge ref_clk);
    frm_done <= 1'b0;
    // Qualifiers are garbled outside a frame so stale values cannot count
    {frm_len, frm_len_type} <= ~{len, lt};
    {frm_vlan, frm_crc_err, frm_any_err, frm_unicast, frm_pause_ok, frm_retried} <= ~fl;
    #1;
  endtask

  // Overflow drops, one per cycle, back to back
  task drop(input [16:0] n);
    frm_ovf_drop <= 1'b1;
    repeat (n) @(posedge ref_clk);
    frm_ovf_drop <= 1'b0;
    #1;
  endtask
endmodule // rxsc_frm_src

// ==== dv/rxsc_top_sva.sv ====
// Port checker for the receive statistics block
`timescale 1ns/1ps
`include "rxsc_defs.vh"

module rxsc_top_sva (
  input wire        ref_clk,
  input wire        sys_rst,
  input wire        frm_done,
  input wire        frm_ovf_drop,
  input wire [31:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [31:0] reg_rdata,
  input wire        cfg_jumbo_en,
  input wire        cfg_size2k_en
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // Address decode helpers
  wire cfg_hit = reg_addr == `RXSC_CFG_ADDR;
  wire narrow  = reg_addr inside {`RXSC_GIANT_CRC_ADDR, `RXSC_SHORT_GOOD_ADDR,
    `RXSC_LONG_GOOD_ADDR, `RXSC_LEN_MISM_ADDR, `RXSC_TYPE_OOR_ADDR, `RXSC_PAUSE_ADDR,
    `RXSC_OVF_DROP_ADDR};
  wire wd_j = reg_wdata[20];
  wire wd_s = reg_wdata[27];

  chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data not zero outside a read answer");
  chk_cfg_reset: assert property ($fell(sys_rst) |-> !cfg_jumbo_en && !cfg_size2k_en)
    else $error("size options not cleared by reset");
  chk_narrow_upper: assert property (reg_rd && narrow |=> reg_rdata[31:16] == 16'h0)
    else $error("narrow counter upper half not zero");
  chk_unmapped_rd: assert property (reg_rd && reg_addr == 32'h440001D8 |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  chk_cfg_write: assert property (reg_wr && cfg_hit |=>
    cfg_jumbo_en == $past(wd_j) && cfg_size2k_en == $past(wd_s))
    else $error("size options not taken from write");
  chk_cfg_hold: assert property (!(reg_wr && cfg_hit) |=>
    $stable(cfg_jumbo_en) && $stable(cfg_size2k_en))
    else $error("size options moved without a write");
  chk_cfg_readback: assert property (reg_rd && cfg_hit |=> reg_rdata ==
    {4'h0, $past(cfg_size2k_en), 6'h0, $past(cfg_jumbo_en), 20'h0})
    else $error("size option readback wrong");
  chk_count_hold: assert property (reg_rd && $past(reg_rd) && reg_addr == $past(reg_addr)
    && !$past(sys_rst) && !$past(frm_done) && !$past(frm_done, 2) && !$past(frm_ovf_drop)
    && !$past(frm_ovf_drop, 2) |=> reg_rdata == $past(reg_rdata))
    else $error("counter moved with no event");
endmodule // rxsc_top_sva

bind rxsc_top rxsc_top_sva u_sva (.ref_clk(ref_clk), .sys_rst(sys_rst), .frm_done(frm_done),
  .frm_ovf_drop(frm_ovf_drop), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cfg_jumbo_en(cfg_jumbo_en),
  .cfg_size2k_en(cfg_size2k_en));

// ==== dv/rxsc_top_tb.sv ====
// Register-level testbench of the receive statistics block
`timescale 1ns/1ps
`include "rxsc_defs.vh"

module rxsc_top_tb;
  logic        ref_clk = 1'b0;   // Core clock
  logic        sys_rst = 1'b1;   // Synchronous reset
  logic        reg_wr = 1'b0;    // Write strobe
  logic        reg_rd = 1'b0;    // Read strobe
  logic [31:0] reg_addr = 32'h0; // Register address
  logic [31:0] reg_wdata = 32'h0;
  wire  [31:0] reg_rdata;
  wire         frm_done, frm_vlan, frm_crc_err, frm_any_err, frm_unicast;
  wire         frm_pause_ok, frm_retried, frm_ovf_drop, cfg_jumbo_en, cfg_size2k_en;
  wire  [13:0] frm_len;
  wire  [15:0] frm_len_type;
  logic [31:0] exp_cnt [14];     // Expected counter values
  logic        jumbo = 1'b0;     // Expected size options
  logic        size2k = 1'b0;
  int          fail_count = 0;
  int          checks = 0;

  always #2 ref_clk = ~ref_clk;

  rxsc_top DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .frm_done(frm_done), .frm_len(frm_len),
    .frm_len_type(frm_len_type), .frm_vlan(frm_vlan), .frm_crc_err(frm_crc_err),
    .frm_any_err(frm_any_err), .frm_unicast(frm_unicast), .frm_pause_ok(frm_pause_ok),
    .frm_retried(frm_retried), .frm_ovf_drop(frm_ovf_drop), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cfg_jumbo_en(cfg_jumbo_en), .cfg_size2k_en(cfg_size2k_en));

  rxsc_frm_src u_src (.ref_clk(ref_clk), .frm_done(frm_done), .frm_len(frm_len),
    .frm_len_type(frm_len_type), .frm_vlan(frm_vlan), .frm_crc_err(frm_crc_err),
    .frm_any_err(frm_any_err), .frm_unicast(frm_unicast), .frm_pause_ok(frm_pause_ok),
    .frm_retried(frm_retried), .frm_ovf_drop(frm_ovf_drop));

  // Bus tasks start and end just after a rising edge
  task wr(input [31:0] a, input [31:0] d);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task rd(input [31:0] a, output [31:0] d);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task cmp(input string nm, input [31:0] e, input [31:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Expected bump, narrow counters wrap at 16 bits
  task bump(input int i, input logic c);
    if (c) exp_cnt[i] = exp_cnt[i] + 32'h1;
    if (!(14'h03F8 >> i & 14'h1)) exp_cnt[i][31:16] = 16'h0;
  endtask

  // Frame with expectations; flags are vlan, crc, err, unicast, pause, retry
  task f(input [13:0] len, input [15:0] lt, input [5:0] fl);
    logic g;
    logic [13:0] mx, gl, pl;
    g = !fl[3];
    mx = size2k ? 14'h07D0 : (fl[5] ? 14'h05F2 : 14'h05EE);
    gl = jumbo ? (fl[5] ? 14'h233E : 14'h233A) : (fl[5] ? 14'h05F2 : 14'h05EE);
    pl = len - (fl[5] ? 14'h0016 : 14'h0012);
    bump(0, fl[4] && len > gl);
    bump(1, g && len < 14'h0040);
    bump(2, g && len > mx);
    bump(3, len == 14'h0040);
    bump(4, len >= 14'h0041 && len <= 14'h007F);
    bump(5, len >= 14'h0080 && len <= 14'h00FF);
    bump(6, len >= 14'h0100 && len <= 14'h01FF);
    bump(7, len >= 14'h0200 && len <= 14'h03FF);
    bump(8, len >= 14'h0400 && len <= mx && !fl[0]);
    bump(9, g && fl[2]);
    bump(10, lt <= 16'h05DC && (lt > {2'h0, pl} || (lt < {2'h0, pl}
      && pl != (fl[5] ? 14'h002A : 14'h002E))));
    bump(11, lt > 16'h05DC && lt < 16'h0600);
    bump(12, g && fl[1]);
    u_src.send(len, lt, fl);
  endtask

  // Reads every counter and the option bits
  task check_all;
    logic [31:0] d;
    repeat (2) @(posedge ref_clk);
    #1;
    for (int i = 0; i < 14; i++) begin
      rd(`RXSC_GIANT_CRC_ADDR + 4 * i, d);
      cmp($sformatf("counter %0d", i), exp_cnt[i], d);
    end
    rd(`RXSC_CFG_ADDR, d);
    cmp("config", {4'h0, size2k, 6'h0, jumbo, 20'h0}, d);
    cmp("option pins", {30'h0, size2k, jumbo}, {30'h0, cfg_size2k_en, cfg_jumbo_en});
  endtask

  task set_cfg(input logic j, input logic s);
    jumbo = j;
    size2k = s;
    wr(`RXSC_CFG_ADDR, {4'h0, s, 6'h0, j, 20'h0});
  endtask

  task do_reset;
    sys_rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    foreach (exp_cnt[i]) exp_cnt[i] = 32'h0;
    jumbo = 1'b0;
    size2k = 1'b0;
    @(posedge ref_clk);
    #1;
  endtask

  task finish_test;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Watchdog well beyond the expected run length
  initial begin
    #(4 * 95000);
    fail_count++;
    finish_test;
  end

  initial begin
    logic [31:0] d;
    do_reset;
    check_all;
    for (int i = 0; i < 14; i++) wr(`RXSC_GIANT_CRC_ADDR + 4 * i, 32'hFFFFFFFF);
    wr(32'h440001D8, 32'hFFFFFFFF);
    rd(32'h440001D8, d);
    cmp("unmapped", 32'h0, d);
    f(14'h003F, 16'h0800, 6'h04); f(14'h003F, 16'h0800, 6'h08);
    f(14'h0040, 16'h0028, 6'h18); f(14'h0040, 16'h0032, 6'h00);
    f(14'h0041, 16'h0800, 6'h00); f(14'h007F, 16'h0800, 6'h0C);
    f(14'h0080, 16'h0064, 6'h00); f(14'h00FF, 16'h05DD, 6'h00);
    f(14'h0100, 16'h05FF, 6'h00); f(14'h01FF, 16'h0600, 6'h00);
    f(14'h0200, 16'h0800, 6'h02); f(14'h03FF, 16'h0800, 6'h0A);
    f(14'h0400, 16'h0800, 6'h00); f(14'h0400, 16'h0800, 6'h01);
    f(14'h05EE, 16'h05DC, 6'h00); f(14'h05EF, 16'h0800, 6'h00);
    f(14'h05EF, 16'h0800, 6'h18); f(14'h05F2, 16'h0800, 6'h38);
    f(14'h05F3, 16'h0800, 6'h38); f(14'h05F2, 16'h0800, 6'h20);
    check_all;
    set_cfg(1'b1, 1'b0);
    f(14'h233A, 16'h0800, 6'h18); f(14'h233B, 16'h0800, 6'h18);
    f(14'h233E, 16'h0800, 6'h38); f(14'h233F, 16'h0800, 6'h38);
    f(14'h05F0, 16'h0800, 6'h18);
    set_cfg(1'b0, 1'b1);
    f(14'h07D0, 16'h0800, 6'h00); f(14'h07D1, 16'h0800, 6'h00);
    f(14'h0640, 16'h0800, 6'h20);
    check_all;
    u_src.drop(17'h0FFFF);
    exp_cnt[13] = 32'h0000FFFF;
    rd(`RXSC_OVF_DROP_ADDR, d);
    rd(`RXSC_OVF_DROP_ADDR, d);
    cmp("drop count full", exp_cnt[13], d);
    u_src.drop(17'h00001);
    bump(13, 1'b0);
    exp_cnt[13] = 32'h0;
    check_all;
    set_cfg(1'b1, 1'b1);
    f(14'h0040, 16'h0800, 6'h04);
    do_reset;
    check_all;
    finish_test;
  end
endmodule // rxsc_top_tb
